// ---- hdl/lsmon_top.sv ----
// Purpose: Channel loss-of-signal monitor with Wishbone status and interrupts.
// Assumes: Classic Wishbone, one-cycle registered ack, inputs synchronous to clk_i.
// Notes: The analog comparators and the E3 detector sit outside this block.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module lsmon_top
  import lsmon_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [LSMON_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [LSMON_DW-1:0] wb_dat_i,
  output logic [LSMON_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_bit_strobe_i,
  input wire logic rx_pulse_i,
  input wire logic amp_below_decl_i,
  input wire logic amp_above_clr_i,
  input wire logic e3_los_i,
  output logic los_o,
  output logic irq_o
);

  function automatic logic addr_is(input logic [LSMON_AW-1:0] adr, input logic [7:0] off);
    addr_is = (adr == off);
  endfunction : addr_is

  logic [1:0] ctrl_mode;
  logic [7:0] int_en;
  logic [7:0] int_stat;
  logic [7:0] prev_stat;
  logic ana_los;
  logic dig_los;

  // Bus decode.
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire new_req = bus_req && !wb_ack_o;
  wire wr_now = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire sel_status = addr_is(wb_adr_i, LSMON_OFF_STATUS);
  wire sel_int_stat = addr_is(wb_adr_i, LSMON_OFF_INT_STAT);
  wire sel_int_clr = addr_is(wb_adr_i, LSMON_OFF_INT_CLR);
  wire sel_int_en = addr_is(wb_adr_i, LSMON_OFF_INT_EN);
  wire sel_ctrl = addr_is(wb_adr_i, LSMON_OFF_CTRL);
  wire wr_int_clr = wr_now && sel_int_clr;
  wire wr_int_en = wr_now && sel_int_en;
  wire wr_ctrl = wr_now && sel_ctrl;

  // Mode decode.
  wire mode_e3 = (ctrl_mode == LSMON_MODE_E3);
  wire mode_tdm = (ctrl_mode == LSMON_MODE_DS3) || (ctrl_mode == LSMON_MODE_STS1);

  // Digital detector runs only in DS3 or STS-1 mode.
  lsmon_dlos u_dlos (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(mode_tdm),
    .bit_strobe_i(rx_bit_strobe_i),
    .pulse_i(rx_pulse_i),
    .los_o(dig_los)
  );

  // Analog hysteresis: declare below one threshold, clear above the other; held clear outside DS3 and STS-1 mode.
  always_ff @(posedge clk_i) begin
    if (rst_i || !mode_tdm) begin
      ana_los <= 1'b0;
    end else if (amp_below_decl_i) begin
      ana_los <= 1'b1;
    end else if (amp_above_clr_i) begin
      ana_los <= 1'b0;
    end
  end

  // Combined loss state.
  wire next_los = mode_e3 ? e3_los_i : (dig_los | ana_los);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      los_o <= 1'b0;
    end else begin
      los_o <= next_los;
    end
  end

  // Status word; only hardware state drives it, so writes to its address cannot alter it.
  wire [7:0] stat_word = {2'b00, dig_los, ana_los, 1'b0, 1'b0, los_o, 1'b0};

  // Control and interrupt enable registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_mode <= LSMON_CTRL_RESET;
      int_en <= LSMON_INT_EN_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_mode <= wb_dat_i[1:0];
      end
      if (wr_int_en) begin
        int_en <= wb_dat_i[7:0] & LSMON_EVT_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_stat <= 8'h00;
    end else begin
      prev_stat <= stat_word;
    end
  end

  // Any change of a detector or combined bit is an event.
  wire [7:0] evt = (stat_word ^ prev_stat) & LSMON_EVT_MASK;
  wire [7:0] clr_mask = wr_int_clr ? wb_dat_i[7:0] : 8'h00;

  // Sticky interrupt bits; a new event wins over a simultaneous clear.
  wire [7:0] next_int_stat;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_int
      if (LSMON_EVT_MASK[gi]) begin : g_live
        assign next_int_stat[gi] = evt[gi] | (int_stat[gi] & ~clr_mask[gi]);
      end else begin : g_zero
        assign next_int_stat[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat <= 8'h00;
    end else begin
      int_stat <= next_int_stat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_stat & int_en);
    end
  end

  // Read mux; unmapped and write-only addresses read as zero.
  wire [7:0] rd_byte =
    sel_status ? stat_word :
    sel_int_stat ? int_stat :
    sel_int_en ? int_en :
    sel_ctrl ? {6'h00, ctrl_mode} :
    8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= new_req;
      if (new_req) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_read_dlos;
    new_req && !wb_we_i && sel_status |=> wb_ack_o && wb_dat_o[5] == $past(dig_los);
  endproperty
  a_read_dlos: assert property (p_read_dlos) else $error("bit 5 mismatch");

  property p_read_alos;
    new_req && !wb_we_i && sel_status |=> wb_ack_o && wb_dat_o[4] == $past(ana_los);
  endproperty
  a_read_alos: assert property (p_read_alos) else $error("bit 4 mismatch");

  property p_read_los;
    new_req && !wb_we_i && sel_status |=> wb_dat_o[1] == $past(los_o);
  endproperty
  a_read_los: assert property (p_read_los) else $error("bit 1 mismatch");

  property p_read_rsvd;
    new_req && !wb_we_i && sel_status |=> wb_dat_o[3] == 1'b0;
  endproperty
  a_read_rsvd: assert property (p_read_rsvd) else $error("bit 3 not zero");

  property p_or;
    mode_tdm && $stable(ctrl_mode) |=> los_o == $past(dig_los | ana_los);
  endproperty
  a_or: assert property (p_or) else $error("combined loss not OR");

  property p_e3;
    mode_e3 |=> los_o == $past(e3_los_i);
  endproperty
  a_e3: assert property (p_e3) else $error("E3 loss not followed");

  property p_alos_decl;
    mode_tdm && amp_below_decl_i && !wr_ctrl |=> ana_los;
  endproperty
  a_alos_decl: assert property (p_alos_decl) else $error("analog not declared");

  property p_alos_hold;
    mode_tdm && !wr_ctrl && ana_los && !amp_above_clr_i |=> ana_los;
  endproperty
  a_alos_hold: assert property (p_alos_hold) else $error("analog cleared early");

  property p_ro;
    wr_now && sel_status && !rx_bit_strobe_i && !amp_below_decl_i && !amp_above_clr_i
      |=> $stable(dig_los) && $stable(ana_los);
  endproperty
  a_ro: assert property (p_ro) else $error("status changed by write");

  property p_set_wins;
    evt[LSMON_BIT_LOS] && clr_mask[LSMON_BIT_LOS] |=> int_stat[LSMON_BIT_LOS];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule : lsmon_top

`default_nettype wire

// ---- hdl/lsmon_pkg.sv ----
// Purpose: Shared constants for the channel loss-of-signal monitor.
// Assumes: 32-bit classic Wishbone slave, registers in the low byte of each word.
// Notes: Bit-period timing is carried by a one-cycle strobe per recovered bit.

package lsmon_pkg;

  localparam int LSMON_AW = 8;
  localparam int LSMON_DW = 32;

  // Register byte offsets.
  localparam logic [7:0] LSMON_OFF_STATUS = 8'h00;
  localparam logic [7:0] LSMON_OFF_INT_STAT = 8'h04;
  localparam logic [7:0] LSMON_OFF_INT_CLR = 8'h08;
  localparam logic [7:0] LSMON_OFF_INT_EN = 8'h0c;
  localparam logic [7:0] LSMON_OFF_CTRL = 8'h10;

  // Status field positions.
  localparam int LSMON_BIT_DLOS = 5;
  localparam int LSMON_BIT_ALOS = 4;
  localparam int LSMON_BIT_RSVD = 3;
  localparam int LSMON_BIT_LOS = 1;
  localparam logic [7:0] LSMON_EVT_MASK = 8'h32;

  // Control register: mode field in bits 1:0.
  localparam logic [1:0] LSMON_MODE_DS3 = 2'h0;
  localparam logic [1:0] LSMON_MODE_STS1 = 2'h1;
  localparam logic [1:0] LSMON_MODE_E3 = 2'h2;
  localparam logic [1:0] LSMON_CTRL_RESET = 2'h0;
  localparam logic [7:0] LSMON_INT_EN_RESET = 8'h00;

  // Digital detector limits: run and window in bit periods, density in percent.
  localparam logic [7:0] LSMON_LOS_RUN = 8'd160;
  localparam int LSMON_DENS_PCT = 33;
  localparam logic [6:0] LSMON_WIN_BITS = 7'd96;
  localparam logic [6:0] LSMON_DENS_MIN =
    7'((int'(LSMON_WIN_BITS) * LSMON_DENS_PCT + 99) / 100);

endpackage : lsmon_pkg

// ---- hdl/lsmon_dlos.sv ----
// Purpose: Digital loss detector counting pulseless bits and pulse density.
// Assumes: bit_strobe_i pulses once per recovered bit period.
// Notes: Density is measured over fixed windows that restart on declaration.

`timescale 1ns/1ps
`default_nettype none

module lsmon_dlos
  import lsmon_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic bit_strobe_i,
  input wire logic pulse_i,
  output logic los_o
);

  logic [7:0] run_cnt;
  logic [6:0] win_cnt;
  logic [6:0] pls_cnt;

  wire hit_run = bit_strobe_i && !pulse_i && (run_cnt == LSMON_LOS_RUN - 8'd1);
  wire win_end = bit_strobe_i && (win_cnt == LSMON_WIN_BITS - 7'd1);
  wire [6:0] pls_total = pls_cnt + {6'h00, pulse_i};
  wire dense = win_end && (pls_total >= LSMON_DENS_MIN);

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      run_cnt <= 8'h00;
    end else if (bit_strobe_i) begin
      if (pulse_i) begin
        run_cnt <= 8'h00;
      end else if (run_cnt != LSMON_LOS_RUN) begin
        run_cnt <= run_cnt + 8'd1;
      end
    end
  end

  // The window restarts on declaration so clearing uses only later bits.
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || hit_run || win_end) begin
      win_cnt <= 7'h00;
      pls_cnt <= 7'h00;
    end else if (bit_strobe_i) begin
      win_cnt <= win_cnt + 7'd1;
      pls_cnt <= pls_total;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      los_o <= 1'b0;
    end else if (hit_run) begin
      los_o <= 1'b1;
    end else if (dense) begin
      los_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_declare_run;
    enable_i && bit_strobe_i && !pulse_i && run_cnt == 8'd159 |=> los_o;
  endproperty
  a_declare_run: assert property (p_declare_run) else $error("no declare after run");

  property p_declare_cause;
    $rose(los_o) |-> $past(run_cnt) == 8'd159 && $past(bit_strobe_i) && !$past(pulse_i);
  endproperty
  a_declare_cause: assert property (p_declare_cause) else $error("early declare");

  property p_clear_dense;
    enable_i && los_o && win_end && pls_total >= 7'd32 && !hit_run |=> !los_o;
  endproperty
  a_clear_dense: assert property (p_clear_dense) else $error("no clear on density");

  property p_clear_cause;
    $fell(los_o) && $past(enable_i) |-> $past(pls_total) >= 7'd32 && $past(win_end);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("clear without density");

  property p_run_reset;
    enable_i && bit_strobe_i && pulse_i |=> run_cnt == 8'h00;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("run not reset by pulse");

  property p_disabled;
    !enable_i |=> !los_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("digital loss outside mode");

endmodule : lsmon_dlos

`default_nettype wire

// ---- test/lsmon_line_model.sv ----
// Purpose: Model of the incoming line as seen after clock recovery and the comparators.
// Assumes: One strobe per recovered bit, never more than one per clock.
// Notes: Between strobes the pulse line toggles so stale values are never trusted.

`timescale 1ns/1ps
`default_nettype none

module lsmon_line_model (
  input wire logic clk_i,
  output logic strobe_o,
  output logic pulse_o,
  output logic below_o,
  output logic above_o
);
  initial begin
    strobe_o = 1'b0;
    pulse_o = 1'b0;
    below_o = 1'b0;
    above_o = 1'b0;
  end

  // Sends n bits, a pulse every k-th bit (none when k is 0), one strobe per gap cycles.
  task automatic send(input int n, input int k, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      strobe_o <= 1'b1;
      pulse_o <= (k != 0) && (i % k == 0);
      repeat (gap - 1) begin
        @(posedge clk_i);
        strobe_o <= 1'b0;
        pulse_o <= ~pulse_o;
      end
    end
    @(posedge clk_i);
    strobe_o <= 1'b0;
  endtask : send

  task automatic set_amp(input logic b, input logic a);
    @(posedge clk_i);
    below_o <= b;
    above_o <= a;
  endtask : set_amp
endmodule : lsmon_line_model

`default_nettype wire

// ---- test/test_loss_of_signal_monitor.sv ----
// Purpose: Self-checking bench for the channel loss-of-signal monitor.
// Assumes: Registers as laid out in the package, one-cycle ack.
// Notes: Status reads wait a few cycles so the combined bit has settled.

`timescale 1ns/1ps
`default_nettype none

module test_loss_of_signal_monitor
  import lsmon_pkg::*;
;
  typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] exp;} lsmon_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, e3_los_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
  logic wb_ack_o, strobe, pulse, below, above, los_o, irq_o;
  int fails = 0;
  int total_checks = 0;
  lsmon_row_t rows[6] = '{
    '{LSMON_OFF_INT_EN, 32'hff, 32'h32},
    '{LSMON_OFF_STATUS, 32'hff, 32'h00},
    '{LSMON_OFF_CTRL, 32'h01, 32'h01},
    '{LSMON_OFF_CTRL, 32'h00, 32'h00},
    '{8'h14, 32'hff, 32'h00},
    '{LSMON_OFF_INT_STAT, 32'hff, 32'h00}};

  always #4 clk_i = ~clk_i;

  lsmon_line_model line_u (.clk_i(clk_i), .strobe_o(strobe), .pulse_o(pulse),
    .below_o(below), .above_o(above));

  lsmon_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_bit_strobe_i(strobe), .rx_pulse_i(pulse),
    .amp_below_decl_i(below), .amp_above_clr_i(above), .e3_los_i(e3_los_i),
    .los_o(los_o), .irq_o(irq_o));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) fails++;
  endtask : wb

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    repeat (4) @(posedge clk_i);
    wb(1'b0, adr, 32'h0, d);
    chk(d, exp);
  endtask : rd_chk

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(LSMON_OFF_STATUS, 32'h0);
    rd_chk(LSMON_OFF_CTRL, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd, d);
      rd_chk(rows[i].adr, rows[i].exp);
    end
    line_u.send(150, 0, 1);
    line_u.send(1, 1, 1);
    line_u.send(150, 0, 1);
    rd_chk(LSMON_OFF_STATUS, 32'h0);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, LSMON_OFF_CTRL, 32'(m), d);
      // A pulse first, so the run count starts from zero in this pass.
      line_u.send(1, 1, m + 1);
      line_u.send(159, 0, m + 1);
      rd_chk(LSMON_OFF_STATUS, 32'h0);
      line_u.send(1, 0, m + 1);
      rd_chk(LSMON_OFF_STATUS, 32'h22);
      chk({31'h0, los_o}, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      rd_chk(LSMON_OFF_INT_STAT, 32'h22);
      wb(1'b1, LSMON_OFF_INT_CLR, 32'h22, d);
      rd_chk(LSMON_OFF_INT_STAT, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      line_u.send(93, 3, m + 1);
      line_u.send(3, 0, m + 1);
      rd_chk(LSMON_OFF_STATUS, 32'h22);
      line_u.send(96, 3, m + 1);
      rd_chk(LSMON_OFF_STATUS, 32'h0);
      chk({31'h0, los_o}, 32'h0);
      wb(1'b1, LSMON_OFF_INT_CLR, 32'h32, d);
    end
    wb(1'b1, LSMON_OFF_INT_EN, 32'h0, d);
    line_u.set_amp(1'b1, 1'b0);
    rd_chk(LSMON_OFF_STATUS, 32'h12);
    chk({31'h0, irq_o}, 32'h0);
    line_u.set_amp(1'b0, 1'b0);
    rd_chk(LSMON_OFF_STATUS, 32'h12);
    wb(1'b1, LSMON_OFF_INT_EN, 32'h10, d);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    line_u.set_amp(1'b0, 1'b1);
    rd_chk(LSMON_OFF_STATUS, 32'h0);
    wb(1'b1, LSMON_OFF_INT_CLR, 32'h32, d);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, LSMON_OFF_CTRL, 32'h2, d);
    e3_los_i <= 1'b1;
    line_u.send(200, 0, 1);
    line_u.set_amp(1'b1, 1'b0);
    rd_chk(LSMON_OFF_STATUS, 32'h02);
    e3_los_i <= 1'b0;
    line_u.set_amp(1'b0, 1'b1);
    rd_chk(LSMON_OFF_STATUS, 32'h0);
    // The combined bit changes one edge before the clear write lands, so its event meets the clear.
    fork
      wb(1'b1, LSMON_OFF_INT_CLR, 32'h02, d);
      begin
        @(posedge clk_i);
        e3_los_i <= 1'b1;
      end
    join
    rd_chk(LSMON_OFF_INT_STAT, 32'h02);
    // Reset in mid-run, with loss declared and a sticky bit set.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(wb_dat_o, 32'h0);
    chk({30'h0, los_o, irq_o}, 32'h0);
    rd_chk(LSMON_OFF_CTRL, 32'h0);
    rd_chk(LSMON_OFF_INT_STAT, 32'h0);
    rd_chk(LSMON_OFF_STATUS, 32'h0);
    tally_and_finish();
  end
endmodule : test_loss_of_signal_monitor

`default_nettype wire
